/* hdl/cdl_card_detect.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// Overview of operation
// - debounced presence rising sets insertion flag if enabled; interrupt if signalled
// - debounced presence falling sets removal flag if enabled; interrupt if signalled
// - full software reset leaves presence and stable bits untouched
// - stable bit reads 0 in reset or debouncing, 1 once settled
// - stable 1 with presence 0 means no card in the socket
// - raw detect bit is undebounced inverse of the detect pin
// - write-protect bit equals the write-protect pin, not inverted
// - four data line levels are readable, showing busy on line zero
// - command line level is readable
// - card detect is debounced before driving the presence bit
module cdl_card_detect
    import cdl_pkg::*;
#(
    parameter int DEBOUNCE_CYC = CDL_DEBOUNCE_CYC
)
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        card_detect_pin,
    input  wire logic        write_protect_pin,
    input  wire logic [3:0]  data_line_pins,
    input  wire logic        command_line_pin,
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    output logic             irq
);

    localparam logic [CDL_CNT_W-1:0] DB_LAST = CDL_CNT_W'(DEBOUNCE_CYC - 1);

    // ========================================================================
    // synchronisers
    // ========================================================================
    cdl_pins_s pins_raw;
    cdl_pins_s sync1_r;
    cdl_pins_s sync2_r;

    assign pins_raw = '{cmd: command_line_pin, dat: data_line_pins,
                        wp: write_protect_pin, cd: card_detect_pin};

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sync1_r <= '{cmd: 1'b1, dat: 4'hf, wp: 1'b1, cd: 1'b1};
            sync2_r <= '{cmd: 1'b1, dat: 4'hf, wp: 1'b1, cd: 1'b1};
        end
        else
        begin
            sync1_r <= pins_raw;
            sync2_r <= sync1_r;
        end
    end

    // ========================================================================
    // debouncer
    // ========================================================================
    cdl_state_e            state_r, state_nxt;
    logic [CDL_CNT_W-1:0]  cnt_r, cnt_nxt;
    logic                  present_r, present_nxt;
    logic                  cand;
    logic                  cand_d_r;

    // pin low means card in the socket
    assign cand = ~sync2_r.cd;

    // presence only moves after a full steady interval; software reset
    // does not reach this process at all, only rst_b does
    always_comb
    begin
        state_nxt   = state_r;
        cnt_nxt     = cnt_r;
        present_nxt = present_r;
        case (state_r)
            CDL_ST_RESET:
            begin
                state_nxt = CDL_ST_BOUNCE;
                cnt_nxt   = '0;
            end
            CDL_ST_BOUNCE:
            begin
                // a wobble restarts the interval, even on its last cycle
                if (cand != cand_d_r)
                    cnt_nxt = '0;
                else if (cnt_r == DB_LAST)
                begin
                    present_nxt = cand;
                    state_nxt   = CDL_ST_STABLE;
                    cnt_nxt     = '0;
                end
                else
                    cnt_nxt = cnt_r + 1'b1;
            end
            CDL_ST_STABLE:
            begin
                if (cand != present_r)
                begin
                    state_nxt = CDL_ST_BOUNCE;
                    cnt_nxt   = '0;
                end
            end
            default:
            begin
                state_nxt = CDL_ST_RESET;
                cnt_nxt   = '0;
            end
        endcase
    end

    // debouncer state; last cycle's level is kept to spot any wobble
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r   <= CDL_ST_RESET;
            cnt_r     <= '0;
            present_r <= 1'b0;
            cand_d_r  <= 1'b0;
        end
        else
        begin
            state_r   <= state_nxt;
            cnt_r     <= cnt_nxt;
            present_r <= present_nxt;
            cand_d_r  <= cand;
        end
    end

    // ========================================================================
    // event flags and interrupt
    // ========================================================================
    logic [1:0] stat_r, stat_nxt;
    logic [1:0] sten_r, sten_nxt;
    logic [1:0] sigen_r, sigen_nxt;
    logic [1:0] ev;
    logic       irq_nxt;

    assign ev[CDL_POS_INS] = present_nxt & ~present_r;
    assign ev[CDL_POS_REM] = ~present_nxt & present_r;

    // write-one-to-clear; a same-cycle event wins over the clear
    always_comb
    begin
        stat_nxt  = stat_r;
        sten_nxt  = sten_r;
        sigen_nxt = sigen_r;
        if (wr && addr == CDL_ADDR_STAT)
            stat_nxt = stat_r & ~wdata[1:0];
        if (wr && addr == CDL_ADDR_STEN)
            sten_nxt = wdata[1:0];
        if (wr && addr == CDL_ADDR_SIGEN)
            sigen_nxt = wdata[1:0];
        // full software reset clears the event side only
        if (wr && addr == CDL_ADDR_SWRST && wdata[CDL_POS_SWRST_ALL])
        begin
            stat_nxt  = CDL_EV_RST;
            sten_nxt  = CDL_EV_RST;
            sigen_nxt = CDL_EV_RST;
        end
        stat_nxt = stat_nxt | (ev & sten_r);
        irq_nxt  = |(stat_nxt & sigen_nxt);
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stat_r  <= CDL_EV_RST;
            sten_r  <= CDL_EV_RST;
            sigen_r <= CDL_EV_RST;
            irq     <= 1'b0;
        end
        else
        begin
            stat_r  <= stat_nxt;
            sten_r  <= sten_nxt;
            sigen_r <= sigen_nxt;
            irq     <= irq_nxt;
        end
    end

    // ========================================================================
    // read port
    // ========================================================================
    logic [31:0] rdata_nxt;
    logic [31:0] pres_word;

    // stable is low in reset and while counting out a change
    always_comb
    begin
        pres_word = '0;
        pres_word[CDL_POS_CARD_PRESENT] = present_r;
        pres_word[CDL_POS_STABLE]       = (state_r == CDL_ST_STABLE);
        pres_word[CDL_POS_CD_RAW]       = ~sync2_r.cd;
        pres_word[CDL_POS_WP]           = sync2_r.wp;
        pres_word[CDL_POS_DAT_LO +: 4]  = sync2_r.dat;
        pres_word[CDL_POS_CMD]          = sync2_r.cmd;
        rdata_nxt = '0;
        if (rd)
        begin
            case (addr)
                CDL_ADDR_PRES:  rdata_nxt = pres_word;
                CDL_ADDR_STAT:  rdata_nxt = {30'h0, stat_r};
                CDL_ADDR_STEN:  rdata_nxt = {30'h0, sten_r};
                CDL_ADDR_SIGEN: rdata_nxt = {30'h0, sigen_r};
                default:        rdata_nxt = '0;  // unmapped and reset reg read zero
            endcase
        end
    end

    // data hold only for the cycle after the strobe
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rdata <= '0;
        else
            rdata <= rdata_nxt;
    end

    // ========================================================================
    // checks
    // ========================================================================
    // the enable that counts is the one standing when presence flips
    sequence s_ins_armed;
        !present_r && sten_r[CDL_POS_INS] ##1 present_r;
    endsequence

    sequence s_rem_armed;
        present_r && sten_r[CDL_POS_REM] ##1 !present_r;
    endsequence

    property p_ins;
        @(posedge clk) disable iff (!rst_b)
        s_ins_armed |-> stat_r[CDL_POS_INS];
    endproperty
    a_ins: assert property (p_ins) else $error("insertion flag missing");

    property p_rem;
        @(posedge clk) disable iff (!rst_b)
        s_rem_armed |-> stat_r[CDL_POS_REM];
    endproperty
    a_rem: assert property (p_rem) else $error("removal flag missing");

    property p_swrst;
        @(posedge clk) disable iff (!rst_b)
        (wr && addr == CDL_ADDR_SWRST && state_r == CDL_ST_STABLE && cand == present_r)
            |=> $stable(present_r) && state_r == CDL_ST_STABLE;
    endproperty
    a_swrst: assert property (p_swrst) else $error("software reset disturbed presence");

    property p_unstable;
        @(posedge clk) disable iff (!rst_b)
        (state_r == CDL_ST_STABLE && cand != present_r) |=> state_r != CDL_ST_STABLE;
    endproperty
    a_unstable: assert property (p_unstable) else $error("stable while changing");

    property p_raw;
        @(posedge clk) disable iff (!rst_b)
        rd && addr == CDL_ADDR_PRES |=> rdata[CDL_POS_CD_RAW] != $past(sync2_r.cd);
    endproperty
    a_raw: assert property (p_raw) else $error("raw detect bit wrong");

    property p_wp;
        @(posedge clk) disable iff (!rst_b)
        rd && addr == CDL_ADDR_PRES |=> rdata[CDL_POS_WP] == $past(sync2_r.wp);
    endproperty
    a_wp: assert property (p_wp) else $error("write protect bit wrong");

    property p_dat;
        @(posedge clk) disable iff (!rst_b)
        rd && addr == CDL_ADDR_PRES |=> rdata[CDL_POS_DAT_LO +: 4] == $past(sync2_r.dat);
    endproperty
    a_dat: assert property (p_dat) else $error("data line field wrong");

    property p_cmd;
        @(posedge clk) disable iff (!rst_b)
        rd && addr == CDL_ADDR_PRES |=> rdata[CDL_POS_CMD] == $past(sync2_r.cmd);
    endproperty
    a_cmd: assert property (p_cmd) else $error("command line bit wrong");

    // the presence bit carries the debounced level, never the raw pin
    property p_pres;
        @(posedge clk) disable iff (!rst_b)
        rd && addr == CDL_ADDR_PRES |=> rdata[CDL_POS_CARD_PRESENT] == $past(present_r);
    endproperty
    a_pres: assert property (p_pres) else $error("presence bit wrong");

    property p_hold;
        @(posedge clk) disable iff (!rst_b)
        $changed(present_r) |-> $past(state_r) == CDL_ST_BOUNCE && $past(cnt_r) == DB_LAST
            && $past(cand) == $past(cand_d_r);
    endproperty
    a_hold: assert property (p_hold) else $error("presence moved early");

    property p_irq;
        @(posedge clk) disable iff (!rst_b)
        irq == (|(stat_r & sigen_r));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt level wrong");

endmodule : cdl_card_detect
`default_nettype wire

/* shared/cdl_pkg.sv */
package cdl_pkg;

    // ========================================================================
    // register map (word index = byte address / 4 not used: plain port)
    // ========================================================================
    localparam logic [3:0] CDL_ADDR_PRES   = 4'h0;  // present/line status, read only
    localparam logic [3:0] CDL_ADDR_STAT   = 4'h1;  // sticky event flags, write 1 to clear
    localparam logic [3:0] CDL_ADDR_STEN   = 4'h2;  // status enable
    localparam logic [3:0] CDL_ADDR_SIGEN  = 4'h3;  // signal (interrupt) enable
    localparam logic [3:0] CDL_ADDR_SWRST  = 4'h4;  // software reset control

    // present-state field positions
    localparam int CDL_POS_CARD_PRESENT = 0;
    localparam int CDL_POS_STABLE       = 1;
    localparam int CDL_POS_CD_RAW       = 2;
    localparam int CDL_POS_WP           = 3;
    localparam int CDL_POS_DAT_LO       = 4;
    localparam int CDL_POS_CMD          = 8;

    // event flag positions (status, enables) and software reset bit position
    localparam int CDL_POS_INS = 0;
    localparam int CDL_POS_REM = 1;
    localparam int CDL_POS_SWRST_ALL = 0;

    // reset values
    localparam logic [1:0] CDL_EV_RST = 2'h0;

    // ========================================================================
    // debounce timing
    // ========================================================================
    localparam int CDL_CLK_MHZ       = 125;
    localparam int CDL_DEBOUNCE_US   = 1;
    localparam int CDL_DEBOUNCE_CYC  = CDL_DEBOUNCE_US * CDL_CLK_MHZ;
    localparam int CDL_CNT_W         = 8;

    // ========================================================================
    // carrier types
    // ========================================================================
    typedef struct packed {
        logic       cmd;
        logic [3:0] dat;
        logic       wp;
        logic       cd;
    } cdl_pins_s;

    typedef enum logic [2:0] {
        CDL_ST_RESET  = 3'b001,
        CDL_ST_BOUNCE = 3'b010,
        CDL_ST_STABLE = 3'b100
    } cdl_state_e;

endpackage : cdl_pkg

/* testbench/cdl_socket_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// card socket with a chattering detect switch
// ============================================================
module cdl_socket_model
#(
    parameter int BOUNCE_CYC = 6
)
(
    input  wire logic       clk,
    input  wire logic       card_in,
    input  wire logic       wp_in,
    input  wire logic [3:0] dat_in,
    input  wire logic       cmd_in,
    output logic            card_detect_pin,
    output logic            write_protect_pin,
    output logic [3:0]      data_line_pins,
    output logic            command_line_pin
);
    logic seen_r = 1'b0;
    int   bounce_r = 0;
    logic cd_r = 1'b1;

    // switch chatters each cycle after a change, so presence must wait it out
    always @(posedge clk)
    begin
        if (card_in !== seen_r)
        begin
            seen_r   <= card_in;
            bounce_r <= BOUNCE_CYC;
        end
        else if (bounce_r > 0)
            bounce_r <= bounce_r - 1;
        cd_r <= (bounce_r > 0) ? ~cd_r : ~seen_r;
    end

    // empty socket: card lines float up to their pull-ups
    assign card_detect_pin   = cd_r;
    assign write_protect_pin = wp_in;
    assign data_line_pins    = seen_r ? dat_in : 4'hf;
    assign command_line_pin  = seen_r ? cmd_in : 1'b1;
endmodule : cdl_socket_model
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import cdl_pkg::*;
;
    localparam int DEB = 4;
    logic        clk, rst_b, card_in, wr, rd, irq, cd, wp, cmd;
    logic [3:0]  addr, dat;
    logic [31:0] wdata, rdata, d;
    cdl_pins_s   lv;
    int          num_errors = 0;
    int          checked = 0;

    cdl_socket_model sock (.clk(clk), .card_in(card_in), .wp_in(lv.wp), .dat_in(lv.dat),
        .cmd_in(lv.cmd), .card_detect_pin(cd), .write_protect_pin(wp),
        .data_line_pins(dat), .command_line_pin(cmd));
    cdl_card_detect #(.DEBOUNCE_CYC(DEB)) uut (.clk(clk), .rst_b(rst_b),
        .card_detect_pin(cd), .write_protect_pin(wp), .data_line_pins(dat),
        .command_line_pin(cmd), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .irq(irq));

    // ============================================================
    // clock and watchdog
    // ============================================================
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // a hang counts as a mismatch
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        stop_test();
    end

    // ============================================================
    // shared tasks
    // ============================================================
    task automatic stop_test;
        if (num_errors == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a; wdata <= v; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    task automatic wait_bits(input logic [31:0] m, input logic [31:0] e);
        logic ok;
        ok = 1'b0;
        for (int i = 0; i < 40 && !ok; i++)
        begin
            rd_reg(CDL_ADDR_PRES);
            ok = ((d & m) === e);
        end
        chk({31'h0, ok}, 32'h1, "presence word never settled");
        if (!ok)
            stop_test();
    endtask : wait_bits

    // settled present word; an empty socket leaves the lines pulled high
    function automatic logic [31:0] pw(input logic p);
        return {23'h0, p ? lv.cmd : 1'b1, p ? lv.dat : 4'hf, lv.wp, p, 1'b1, p};
    endfunction : pw

    task automatic chk_regs(input logic [1:0] st, input logic [1:0] en, input logic q);
        rd_reg(CDL_ADDR_STAT); chk(d, {30'h0, st}, "status");
        rd_reg(CDL_ADDR_STEN); chk(d, {30'h0, en}, "status enable");
        rd_reg(CDL_ADDR_SIGEN); chk(d, {30'h0, en}, "signal enable");
        chk({31'h0, irq}, {31'h0, q}, "irq");
    endtask : chk_regs

    // ============================================================
    // scenarios
    // ============================================================
    task automatic t_reset;
        rd_reg(CDL_ADDR_PRES); chk(d & 32'h3, 32'h0, "stable early");
        wait_bits(32'h2, 32'h2);
        chk(d, pw(1'b0), "empty socket word");
        chk_regs(2'h0, 2'h0, 1'b0);
        rd_reg(CDL_ADDR_SWRST); chk(d, 32'h0, "reset ctl read");
        rd_reg(4'hf); chk(d, 32'h0, "unmapped read");
    endtask : t_reset

    task automatic t_insert;
        wr_reg(CDL_ADDR_STEN, 32'h3);
        wr_reg(CDL_ADDR_SIGEN, 32'h3);
        card_in <= 1'b1;
        repeat (4) @(posedge clk);
        rd_reg(CDL_ADDR_PRES); chk(d & 32'h3, 32'h0, "bouncing");
        wait_bits(32'h3, 32'h3);
        chk_regs(2'h1, 2'h3, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            lv.wp <= i[0]; lv.dat <= 4'h1 << i; lv.cmd <= ~i[0];
            repeat (4) @(posedge clk);
            rd_reg(CDL_ADDR_PRES); chk(d, pw(1'b1), "line levels");
        end
        wr_reg(CDL_ADDR_SIGEN, 32'h0);
        #1 chk({31'h0, irq}, 32'h0, "masked irq");
        wr_reg(CDL_ADDR_SIGEN, 32'h3);
        wr_reg(CDL_ADDR_STAT, 32'h1);
        chk_regs(2'h0, 2'h3, 1'b0);
    endtask : t_insert

    task automatic t_remove;
        wr_reg(CDL_ADDR_STEN, 32'h1);
        card_in <= 1'b0;
        wait_bits(32'h3, 32'h2);
        rd_reg(CDL_ADDR_STAT); chk(d, 32'h0, "gated removal");
        wr_reg(CDL_ADDR_STEN, 32'h3);
        card_in <= 1'b1;
        wait_bits(32'h3, 32'h3);
        wr_reg(CDL_ADDR_STAT, 32'h1);
        card_in <= 1'b0;
        wait_bits(32'h3, 32'h2);
        chk_regs(2'h2, 2'h3, 1'b1);
    endtask : t_remove

    task automatic t_swrst;
        card_in <= 1'b1;
        wait_bits(32'h3, 32'h3);
        wr_reg(CDL_ADDR_SWRST, 32'h1);
        rd_reg(CDL_ADDR_PRES); chk(d, pw(1'b1), "word after soft reset");
        chk_regs(2'h0, 2'h0, 1'b0);
    endtask : t_swrst

    // reset in mid-run with a card seated: presence starts over from empty
    task automatic t_rst_mid;
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rd_reg(CDL_ADDR_PRES); chk(d & 32'h3, 32'h0, "stable after reset");
        wait_bits(32'h3, 32'h3);
        chk(d, pw(1'b1), "word after reset");
        chk_regs(2'h0, 2'h0, 1'b0);
    endtask : t_rst_mid

    // ============================================================
    // main sequence
    // ============================================================
    initial
    begin
        rst_b = 1'b0; card_in = 1'b0; wr = 1'b0; rd = 1'b0;
        addr = 4'h0; wdata = 32'h0; lv = '0; lv.wp = 1'b1;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_insert();
        t_remove();
        t_swrst();
        t_rst_mid();
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
